/* File: i2c_pkg.sv */
package i2c_pkg;
  localparam int CLK_NS       = 100;
  localparam int SCL_LOW_NS   = 5000;
  localparam int SCL_HIGH_NS  = 4000;
  localparam int HOLD_NS      = 4000;
  localparam int SCL_LOW_CYC  = (SCL_LOW_NS + CLK_NS - 1) / CLK_NS;
  localparam int SCL_HIGH_CYC = (SCL_HIGH_NS + CLK_NS - 1) / CLK_NS;
  localparam int HOLD_CYC     = (HOLD_NS + CLK_NS - 1) / CLK_NS;
  localparam int TICK_DIV     = 64;
  localparam int IDLE_SHIFT   = 9;

  localparam logic [3:0] OFS_CTRL   = 4'h0;
  localparam logic [3:0] OFS_OWN    = 4'h1;
  localparam logic [3:0] OFS_DATA   = 4'h2;
  localparam logic [3:0] OFS_STAT   = 4'h3;
  localparam logic [3:0] OFS_SLT_HI = 4'h9;
  localparam logic [3:0] OFS_SLT_LO = 4'hA;

  localparam logic [7:0] SLT_HI_RST = 8'h00;
  localparam logic [7:0] SLT_LO_RST = 8'h00;
  localparam logic [6:0] OWN_RST    = 7'h00;

  localparam int C_EN   = 0;
  localparam int C_ACK  = 1;
  localparam int C_TCK  = 2;
  localparam int C_STA  = 3;
  localparam int C_STO  = 4;
  localparam int C_RSTA = 5;

  localparam int S_BUSY = 0;
  localparam int S_MST  = 1;
  localparam int S_SLV  = 2;
  localparam int S_SRW  = 3;
  localparam int S_DONE = 4;
  localparam int S_ARB  = 5;
  localparam int S_NACK = 6;
  localparam int S_AERR = 7;
  localparam int S_LTO  = 8;
  localparam int S_IDLE = 9;

  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [3:0]  addr;
    logic [15:0] wdata;
  } reg_req_t;

  typedef struct packed {
    logic scl;
    logic sda;
  } lines_t;

  typedef enum logic [2:0] {
    M_IDLE, M_START, M_BITS, M_WAIT, M_STOP_A, M_STOP_B, M_RSTA_A, M_RSTA_B
  } mst_st_t;

  typedef enum logic [1:0] {T_LOW, T_WAIT, T_HIGH} tmr_st_t;
endpackage

/* File: scl_timer.sv */
`timescale 1ns/1ps
module scl_timer
  import i2c_pkg::*;
#(
  parameter int LOW_CYC  = SCL_LOW_CYC,
  parameter int HIGH_CYC = SCL_HIGH_CYC
)(
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic run,
  input  wire logic scl_in,
  output logic      hold_low
);
  typedef struct packed {
    tmr_st_t    ph;
    logic [7:0] cnt;
  } tmr_t;

  tmr_t st_ff;
  tmr_t nxt;

  always_comb begin
    nxt = st_ff;
    nxt.cnt = st_ff.cnt + 8'h01;
    if (!run) begin
      nxt.ph = T_LOW;
      nxt.cnt = '0;
    end else begin
      unique case (st_ff.ph)
        T_LOW: if (st_ff.cnt == 8'(LOW_CYC - 1)) nxt.ph = T_WAIT;
        T_WAIT: begin
          // another device may still hold the line low
          nxt.cnt = '0;
          if (scl_in) nxt.ph = T_HIGH;
        end
        T_HIGH: begin
          if (!scl_in || st_ff.cnt == 8'(HIGH_CYC - 1)) begin
            nxt.ph = T_LOW;
            nxt.cnt = '0;
          end
        end
        default: nxt.ph = T_LOW;
      endcase
    end
  end

  assign hold_low = run & (st_ff.ph == T_LOW);

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st_ff <= '{ph: T_LOW, cnt: 8'h00};
    end else begin
      st_ff <= nxt;
    end
  end

  a_low_after_fall:
    assert property (@(posedge clk) disable iff (rst)
      (run && st_ff.ph == T_HIGH && !scl_in) |=> (hold_low || !run))
    else $error("clock low period not started on falling edge");
endmodule

/* File: timeout_unit.sv */
`timescale 1ns/1ps
module timeout_unit
  import i2c_pkg::*;
#(
  parameter int DIV = TICK_DIV
)(
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire lines_t      lines_in,
  input  wire logic        tck_fast,
  input  wire logic [15:0] threshold,
  output logic             low_timeout,
  output logic             bus_idle
);
  localparam int PW = $clog2(DIV);

  typedef struct packed {
    logic [PW-1:0] pre;
    logic [15:0]   low_cnt;
    logic [15:0]   high_cnt;
    logic          fired;
  } tmo_t;

  tmo_t st_ff;
  tmo_t nxt;
  logic tick;

  assign tick = tck_fast | (st_ff.pre == PW'(DIV - 1));

  always_comb begin
    nxt = st_ff;
    nxt.pre = tick ? '0 : st_ff.pre + 1'b1;
    if (lines_in.scl) begin
      nxt.low_cnt = '0;
      nxt.fired = 1'b0;
    end else if (tick && st_ff.low_cnt != '1) begin
      nxt.low_cnt = st_ff.low_cnt + 16'h0001;
    end
    if (low_timeout) nxt.fired = 1'b1;
    if (lines_in.scl && lines_in.sda) begin
      if (tick && st_ff.high_cnt != '1) nxt.high_cnt = st_ff.high_cnt + 16'h0001;
    end else begin
      nxt.high_cnt = '0;
    end
  end

  // one pulse per low interval; zero threshold disables
  assign low_timeout = (threshold != 16'h0000) && !st_ff.fired &&
                       !lines_in.scl && st_ff.low_cnt > threshold;
  assign bus_idle = st_ff.high_cnt > 16'(threshold >> IDLE_SHIFT);

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt;
    end
  end

  a_lto_cause:
    assert property (@(posedge clk) disable iff (rst)
      low_timeout |-> (threshold != 16'h0000) && !lines_in.scl)
    else $error("low timeout without cause");

  a_idle_drop:
    assert property (@(posedge clk) disable iff (rst)
      !(lines_in.scl && lines_in.sda) |=> !bus_idle)
    else $error("bus idle kept while a line is low");
endmodule

/* File: i2c_engine.sv */
`timescale 1ns/1ps
module i2c_engine
  import i2c_pkg::*;
(
  input  wire logic     clk,
  input  wire logic     rst,
  input  wire reg_req_t req,
  output logic [15:0]   rdata,
  input  wire lines_t   lines_in,
  output lines_t        lines_out,
  output lines_t        lines_oe
);
  typedef struct packed {
    logic        en;
    logic        ack_en;
    logic        tck_fast;
    logic [6:0]  own;
    logic [7:0]  slt_hi;
    logic [7:0]  slt_lo;
    logic [7:0]  tx;
    logic [7:0]  rx;
    logic [7:0]  sh;
    logic [3:0]  bitn;
    mst_st_t     mst;
    logic        master;
    logic        listen;
    logic        addr_ph;
    logic        xmit;
    logic        slv;
    logic        srw;
    logic        busy;
    logic        go;
    logic        done;
    logic        arb;
    logic        nack;
    logic        aerr;
    logic        lto;
    logic        mhold;
    logic        stretch;
    logic        run;
    logic [7:0]  cnt;
    logic        scl_prev;
    logic        sda_prev;
    logic        scl_oe;
    logic        sda_oe;
    logic [15:0] rdata;
  } state_t;

  localparam state_t RST_ST = '{slt_hi: SLT_HI_RST, slt_lo: SLT_LO_RST,
                                own: OWN_RST, mst: M_IDLE, default: '0};

  state_t st_ff;
  state_t nxt;
  logic   scl;
  logic   sda;
  logic   fall;
  logic   rise;
  logic   start_det;
  logic   stop_det;
  logic   engaged;
  logic   own_hit;
  logic   ack_want;
  logic   hold_end;
  logic   wr_ctrl;
  logic   wr_stat;
  logic   tmr_hold;
  logic   lto_pulse;
  logic   bus_idle;

  assign scl       = lines_in.scl;
  assign sda       = lines_in.sda;
  assign fall      = st_ff.scl_prev & ~scl;
  assign rise      = ~st_ff.scl_prev & scl;
  assign start_det = scl & st_ff.scl_prev & st_ff.sda_prev & ~sda;
  assign stop_det  = scl & st_ff.scl_prev & ~st_ff.sda_prev & sda;
  assign engaged   = st_ff.master | st_ff.listen;
  assign own_hit   = st_ff.en & (st_ff.sh[7:1] == st_ff.own);
  assign ack_want  = st_ff.addr_ph ? (own_hit & ~st_ff.master) : st_ff.ack_en;
  assign hold_end  = st_ff.cnt == 8'(HOLD_CYC - 1);
  assign wr_ctrl   = req.wr && req.addr == OFS_CTRL;
  assign wr_stat   = req.wr && req.addr == OFS_STAT;

  // write-one-to-clear; a set applied later in the process wins
  function automatic logic kept(logic cur, int pos);
    return cur & ~(wr_stat & req.wdata[pos]);
  endfunction

  always_comb begin
    nxt = st_ff;
    nxt.scl_prev = scl;
    nxt.sda_prev = sda;
    nxt.rdata = '0;
    nxt.done = kept(st_ff.done, S_DONE);
    nxt.arb = kept(st_ff.arb, S_ARB);
    nxt.aerr = kept(st_ff.aerr, S_AERR);
    nxt.lto = kept(st_ff.lto, S_LTO);
    if (lto_pulse) nxt.lto = 1'b1;

    if (req.wr) begin
      case (req.addr)
        OFS_CTRL: begin
          nxt.en = req.wdata[C_EN];
          nxt.ack_en = req.wdata[C_ACK];
          nxt.tck_fast = req.wdata[C_TCK];
        end
        OFS_OWN: nxt.own = req.wdata[7:1];
        OFS_DATA: begin
          nxt.tx = req.wdata[7:0];
          nxt.go = 1'b1;
        end
        OFS_SLT_HI: nxt.slt_hi = req.wdata[7:0];
        OFS_SLT_LO: nxt.slt_lo = req.wdata[7:0];
        default: ;
      endcase
    end

    if (req.rd) begin
      case (req.addr)
        OFS_CTRL: begin
          nxt.rdata[C_EN] = st_ff.en;
          nxt.rdata[C_ACK] = st_ff.ack_en;
          nxt.rdata[C_TCK] = st_ff.tck_fast;
        end
        OFS_OWN: nxt.rdata = {8'h00, st_ff.own, 1'b0};
        OFS_DATA: nxt.rdata = {8'h00, st_ff.rx};
        OFS_STAT: begin
          nxt.rdata[S_BUSY] = st_ff.busy;
          nxt.rdata[S_MST] = st_ff.master;
          nxt.rdata[S_SLV] = st_ff.slv;
          nxt.rdata[S_SRW] = st_ff.srw;
          nxt.rdata[S_DONE] = st_ff.done;
          nxt.rdata[S_ARB] = st_ff.arb;
          nxt.rdata[S_NACK] = st_ff.nack;
          nxt.rdata[S_AERR] = st_ff.aerr;
          nxt.rdata[S_LTO] = st_ff.lto;
          nxt.rdata[S_IDLE] = bus_idle;
        end
        OFS_SLT_HI: nxt.rdata = {8'h00, st_ff.slt_hi};
        OFS_SLT_LO: nxt.rdata = {8'h00, st_ff.slt_lo};
        default: ;
      endcase
    end

    if (start_det) begin
      nxt.busy = 1'b1;
      nxt.bitn = '0;
      nxt.addr_ph = 1'b1;
      nxt.slv = 1'b0;
      nxt.nack = 1'b0;
      nxt.stretch = 1'b0;
      nxt.listen = ~st_ff.master & st_ff.en;
      nxt.xmit = st_ff.master;
      if (st_ff.master) nxt.sh = st_ff.tx;
      else nxt.sda_oe = 1'b0;
    end

    if (engaged && rise) begin
      if (st_ff.bitn < 4'h8) begin
        nxt.sh = {st_ff.sh[6:0], sda};
        nxt.bitn = st_ff.bitn + 4'h1;
        if (st_ff.master && st_ff.xmit && st_ff.sh[7] && !sda) begin
          // address bits keep shifting so our own address still matches
          nxt.master = 1'b0;
          nxt.mst = M_IDLE;
          nxt.run = 1'b0;
          nxt.sda_oe = 1'b0;
          nxt.arb = 1'b1;
          nxt.listen = 1'b1;
          nxt.xmit = 1'b0;
        end
      end else if (st_ff.bitn == 4'h8) begin
        nxt.bitn = 4'h9;
        nxt.addr_ph = 1'b0;
        if (st_ff.xmit) nxt.nack = sda;
        if (st_ff.addr_ph && !st_ff.master) begin
          if (own_hit) begin
            nxt.slv = 1'b1;
            nxt.srw = st_ff.sh[0];
            nxt.xmit = st_ff.sh[0];
          end else begin
            nxt.listen = 1'b0;
          end
        end else if (st_ff.addr_ph) begin
          nxt.xmit = ~st_ff.sh[0];
        end else if (!st_ff.master && st_ff.xmit && sda) begin
          nxt.listen = 1'b0;
          nxt.slv = 1'b0;
          nxt.xmit = 1'b0;
        end
      end
    end

    if (engaged && fall) begin
      if (st_ff.bitn < 4'h8) begin
        nxt.sda_oe = st_ff.xmit & ~st_ff.sh[7];
      end else if (st_ff.bitn == 4'h8) begin
        nxt.sda_oe = ~st_ff.xmit & ack_want;
      end else begin
        nxt.sda_oe = 1'b0;
        nxt.bitn = '0;
        nxt.rx = st_ff.sh;
        nxt.done = 1'b1;
        if (st_ff.master) begin
          nxt.mst = M_WAIT;
          nxt.mhold = 1'b1;
          nxt.run = 1'b0;
        end else if (st_ff.slv) begin
          // a data write left from before the byte must not end the stretch
          nxt.stretch = 1'b1;
          nxt.go = req.wr && req.addr == OFS_DATA;
        end
      end
    end

    // data write releases the stretch; first bit is driven in the same cycle
    if (st_ff.stretch && st_ff.go) begin
      nxt.stretch = 1'b0;
      nxt.go = 1'b0;
      if (st_ff.xmit) begin
        nxt.sh = st_ff.tx;
        nxt.sda_oe = ~st_ff.tx[7];
      end
    end

    unique case (st_ff.mst)
      M_IDLE: begin
        if (wr_ctrl && req.wdata[C_STA]) begin
          if (st_ff.tx[7:1] == st_ff.own) begin
            nxt.aerr = 1'b1;
          end else if (st_ff.busy || !st_ff.en) begin
            nxt.arb = 1'b1;
          end else begin
            nxt.master = 1'b1;
            nxt.listen = 1'b0;
            nxt.sda_oe = 1'b1;
            nxt.cnt = '0;
            nxt.go = 1'b0;
            nxt.mst = M_START;
          end
        end
      end
      M_START: begin
        nxt.cnt = st_ff.cnt + 8'h01;
        if (hold_end) begin
          nxt.mst = M_BITS;
          nxt.run = 1'b1;
        end
      end
      M_BITS: ;
      M_WAIT: begin
        // a failed byte leaves only stop or repeated start
        if (wr_ctrl && req.wdata[C_STO]) begin
          nxt.mst = M_STOP_A;
          nxt.sda_oe = 1'b1;
          nxt.cnt = '0;
        end else if (wr_ctrl && req.wdata[C_RSTA]) begin
          nxt.mst = M_RSTA_A;
          nxt.sda_oe = 1'b0;
          nxt.cnt = '0;
        end else if (st_ff.go && !st_ff.nack) begin
          nxt.go = 1'b0;
          nxt.mhold = 1'b0;
          nxt.run = 1'b1;
          nxt.mst = M_BITS;
          if (st_ff.xmit) begin
            nxt.sh = st_ff.tx;
            nxt.sda_oe = ~st_ff.tx[7];
          end
        end
      end
      M_STOP_A, M_RSTA_A: begin
        nxt.cnt = st_ff.cnt + 8'h01;
        if (hold_end) begin
          nxt.mhold = 1'b0;
          nxt.cnt = '0;
          nxt.mst = (st_ff.mst == M_STOP_A) ? M_STOP_B : M_RSTA_B;
        end
      end
      M_STOP_B: begin
        // waits out any stretch before the setup time runs
        if (scl) nxt.cnt = st_ff.cnt + 8'h01;
        if (scl && hold_end) nxt.sda_oe = 1'b0;
      end
      M_RSTA_B: begin
        if (scl) nxt.cnt = st_ff.cnt + 8'h01;
        if (scl && hold_end) begin
          nxt.sda_oe = 1'b1;
          nxt.cnt = '0;
          nxt.mst = M_START;
        end
      end
    endcase

    if (stop_det) begin
      nxt.busy = 1'b0;
      nxt.listen = 1'b0;
      nxt.slv = 1'b0;
      nxt.master = 1'b0;
      nxt.mst = M_IDLE;
      nxt.sda_oe = 1'b0;
      nxt.stretch = 1'b0;
      nxt.run = 1'b0;
      nxt.mhold = 1'b0;
    end

    nxt.scl_oe = tmr_hold | nxt.mhold | nxt.stretch;
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st_ff <= RST_ST;
    end else begin
      st_ff <= nxt;
    end
  end

  scl_timer u_timer (
    .clk      (clk),
    .rst      (rst),
    .run      (st_ff.run),
    .scl_in   (scl),
    .hold_low (tmr_hold)
  );

  timeout_unit u_timeout (
    .clk         (clk),
    .rst         (rst),
    .lines_in    (lines_in),
    .tck_fast    (st_ff.tck_fast),
    .threshold   ({st_ff.slt_hi, st_ff.slt_lo}),
    .low_timeout (lto_pulse),
    .bus_idle    (bus_idle)
  );

  // open drain: level is always low, only the enable moves
  assign lines_out = '0;
  assign lines_oe = '{scl: st_ff.scl_oe, sda: st_ff.sda_oe};
  assign rdata = st_ff.rdata;

  a_slt_hi_read:
    assert property (@(posedge clk) disable iff (rst)
      (req.rd && req.addr == OFS_SLT_HI) |=> rdata == {8'h00, $past(st_ff.slt_hi)})
    else $error("timeout high byte read wrong");

  a_slt_lo_read:
    assert property (@(posedge clk) disable iff (rst)
      (req.rd && req.addr == OFS_SLT_LO) |=> rdata == {8'h00, $past(st_ff.slt_lo)})
    else $error("timeout low byte read wrong");

  a_ack_own_match:
    assert property (@(posedge clk) disable iff (rst)
      (st_ff.listen && st_ff.addr_ph && st_ff.bitn == 4'h8 && st_ff.sda_oe)
      |-> st_ff.sh[7:1] == st_ff.own)
    else $error("slave acked a foreign address");

  a_single_role:
    assert property (@(posedge clk) disable iff (rst)
      !(st_ff.master && (st_ff.listen || st_ff.slv)))
    else $error("master and slave at once");

  a_arb_lost_drop:
    assert property (@(posedge clk) disable iff (rst)
      (st_ff.master && st_ff.xmit && rise && st_ff.bitn < 4'h8 &&
       st_ff.sh[7] && !sda)
      |=> !st_ff.master && !st_ff.sda_oe && st_ff.arb && st_ff.listen)
    else $error("arbitration loss not handled");

  a_start_bus_free:
    assert property (@(posedge clk) disable iff (rst)
      $rose(st_ff.master) |-> !$past(st_ff.busy))
    else $error("start issued on busy bus");

  a_sda_steady_high:
    assert property (@(posedge clk) disable iff (rst)
      (st_ff.mst == M_BITS && scl && st_ff.scl_prev) |=> $stable(st_ff.sda_oe))
    else $error("data changed while clock high");

  a_stretch_hold:
    assert property (@(posedge clk) disable iff (rst)
      (st_ff.slv && st_ff.bitn == 4'h9 && fall && !stop_det)
      |=> st_ff.stretch ##1 lines_oe.scl)
    else $error("slave did not stretch after byte");

  a_lto_sticky:
    assert property (@(posedge clk) disable iff (rst)
      (st_ff.lto && !(wr_stat && req.wdata[S_LTO])) |=> st_ff.lto)
    else $error("timeout flag lost without clear");
endmodule

/* File: bus_partner.sv */
`timescale 1ns/1ps
module bus_partner #(
  parameter int HALF = 60
)(
  input  wire logic clk,
  input  wire logic scl,
  input  wire logic sda,
  output logic      scl_oe,
  output logic      sda_oe
);
  logic       slave_on;
  logic       ack_en;
  logic       scl_ff;
  logic       sda_ff;
  logic [3:0] cnt_ff;
  logic [7:0] shift_ff;
  logic [7:0] got_ff;
  logic       stop_ff;
  logic       stuck;

  initial begin
    {scl_oe, sda_oe, slave_on, cnt_ff, shift_ff, got_ff, stop_ff} = '0;
    stuck = 1'b0;
    {ack_en, scl_ff, sda_ff} = '1;
  end

  // slave receiver; idle while the tasks below play master
  always @(posedge clk) begin
    scl_ff <= scl;
    sda_ff <= sda;
    if (slave_on) begin
      if (scl && scl_ff && sda_ff && !sda) begin
        cnt_ff <= 4'h0;
      end else if (scl && scl_ff && !sda_ff && sda) begin
        stop_ff <= 1'b1;
      end else if (scl && !scl_ff) begin
        shift_ff <= {shift_ff[6:0], sda};
        cnt_ff   <= cnt_ff + 4'h1;
      end else if (!scl && scl_ff && cnt_ff == 4'h8) begin
        got_ff <= shift_ff;
        sda_oe <= ack_en;
      end else if (!scl && scl_ff && cnt_ff == 4'h9) begin
        sda_oe <= 1'b0;
        cnt_ff <= 4'h0;
      end
    end
  end

  task automatic wait_cyc(input int n);
    repeat (n) @(posedge clk);
  endtask

  // bounded so a stuck stretch cannot hang the run
  task automatic release_scl();
    scl_oe <= 1'b0;
    for (int k = 0; k < 4000 && !scl; k++) @(posedge clk);
    if (!scl) stuck = 1'b1;
  endtask

  task automatic start_cond();
    sda_oe <= 1'b0;
    wait_cyc(HALF);
    release_scl();
    wait_cyc(HALF);
    sda_oe <= 1'b1;
    wait_cyc(HALF);
    scl_oe <= 1'b1;
    wait_cyc(HALF);
  endtask

  task automatic send_bit(input logic b, output logic s);
    sda_oe <= !b;
    wait_cyc(HALF);
    release_scl();
    wait_cyc(HALF);
    s = sda;
    scl_oe <= 1'b1;
    wait_cyc(HALF);
  endtask

  task automatic send_byte(input logic [7:0] b, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) send_bit(b[i], s);
    send_bit(1'b1, ack);
  endtask

  task automatic stop_cond();
    sda_oe <= 1'b1;
    wait_cyc(HALF);
    release_scl();
    wait_cyc(HALF);
    sda_oe <= 1'b0;
    wait_cyc(HALF);
  endtask
endmodule

/* File: i2c_bus_protocol_engine_test.sv */
`timescale 1ns/1ps
module i2c_bus_protocol_engine_test
  import i2c_pkg::*;
;
  logic        clk;
  logic        rst;
  reg_req_t    req;
  logic [15:0] rdata;
  lines_t      lines_in;
  lines_t      lines_out;
  lines_t      lines_oe;
  logic        p_scl_oe;
  logic        p_sda_oe;
  logic        scl;
  logic        sda;
  int          err_count;
  int          num_checks;
  int          slt_mdl[2];
  logic [7:0]  byte_q[$];
  logic [15:0] rd_v;
  logic [6:0]  own;
  logic [7:0]  thr;
  logic        ack;

  // wired and with pull-ups
  assign scl      = !(lines_oe.scl | p_scl_oe);
  assign sda      = !(lines_oe.sda | p_sda_oe);
  assign lines_in = {scl, sda};

  i2c_engine i_dut (
    .clk       (clk),
    .rst       (rst),
    .req       (req),
    .rdata     (rdata),
    .lines_in  (lines_in),
    .lines_out (lines_out),
    .lines_oe  (lines_oe)
  );

  bus_partner #(.HALF(60)) i_partner (
    .clk    (clk),
    .scl    (scl),
    .sda    (sda),
    .scl_oe (p_scl_oe),
    .sda_oe (p_sda_oe)
  );

  always #50 clk = ~clk;

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic check_bit(input logic got, input logic exp);
    check({15'h0000, got}, {15'h0000, exp});
  endtask

  task automatic reg_wr(input logic [3:0] a, input logic [15:0] d);
    req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge clk);
    req <= '0;
    @(posedge clk);
  endtask

  task automatic reg_rd(input logic [3:0] a, output logic [15:0] d);
    req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 16'h0000};
    @(posedge clk);
    req <= '0;
    @(negedge clk);
    d = rdata;
    @(posedge clk);
  endtask

  task automatic wait_stat(input int bit_no);
    for (int k = 0; k < 3000; k++) begin
      reg_rd(OFS_STAT, rd_v);
      if (rd_v[bit_no] === 1'b1) return;
    end
    err_count++;
    $display("wait limit reached at %0t", $time);
    wrap_up();
  endtask

  initial begin
    clk = 1'b0;
    rst = 1'b1;
    req = '0;
    err_count = 0;
    num_checks = 0;
    void'($urandom(32'h518A));
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);

    reg_rd(OFS_SLT_HI, rd_v);
    check(rd_v, {8'h00, SLT_HI_RST});
    reg_rd(OFS_SLT_LO, rd_v);
    check(rd_v, 16'h0000);
    for (int i = 0; i < 6; i++) begin
      slt_mdl[i % 2] = $urandom;
      reg_wr(i % 2 ? OFS_SLT_LO : OFS_SLT_HI, 16'(slt_mdl[i % 2]));
      reg_rd(OFS_SLT_HI, rd_v);
      check(rd_v, {8'h00, 8'(slt_mdl[0])});
      reg_rd(OFS_SLT_LO, rd_v);
      check(rd_v, {8'h00, 8'(slt_mdl[1])});
    end
    reg_rd(4'hF, rd_v);
    check(rd_v, 16'h0000);
    $display("registers test done");

    // own address as target must be refused without bus action
    own = 7'($urandom_range(1, 126));
    reg_wr(OFS_OWN, {8'h00, own, 1'b0});
    reg_rd(OFS_OWN, rd_v);
    check(rd_v, {8'h00, own, 1'b0});
    reg_wr(OFS_DATA, {8'h00, own, 1'b0});
    reg_wr(OFS_CTRL, 16'h0009);
    repeat (45) @(posedge clk);
    check_bit(lines_oe.sda, 1'b0);
    reg_rd(OFS_STAT, rd_v);
    check_bit(rd_v[S_AERR], 1'b1);
    reg_wr(OFS_STAT, 16'h00A0);
    $display("own address test done");

    // master write: acked address, nacked data, then stop
    i_partner.slave_on = 1'b1;
    i_partner.ack_en = 1'b1;
    byte_q.push_back({own ^ 7'h40, 1'b0});
    byte_q.push_back(8'($urandom));
    reg_wr(OFS_DATA, {8'h00, byte_q[0]});
    reg_wr(OFS_CTRL, 16'h0009);
    wait_stat(S_DONE);
    check({8'h00, i_partner.got_ff}, {8'h00, byte_q.pop_front()});
    check_bit(rd_v[S_NACK], 1'b0);
    reg_wr(OFS_STAT, 16'h0010);
    i_partner.ack_en = 1'b0;
    reg_wr(OFS_DATA, {8'h00, byte_q[0]});
    wait_stat(S_DONE);
    check({8'h00, i_partner.got_ff}, {8'h00, byte_q.pop_front()});
    check_bit(rd_v[S_NACK], 1'b1);
    reg_wr(OFS_CTRL, 16'h0011);
    for (int k = 0; k < 2000 && !i_partner.stop_ff; k++) @(posedge clk);
    check_bit(i_partner.stop_ff, 1'b1);
    if (i_partner.stop_ff !== 1'b1) wrap_up();
    repeat (2) @(posedge clk);
    check({14'h0000, lines_oe}, 16'h0000);
    $display("master test done");

    // slave role under another master, with a short timeout threshold
    i_partner.slave_on = 1'b0;
    thr = 8'($urandom_range(8, 30));
    reg_wr(OFS_SLT_HI, 16'h0000);
    reg_wr(OFS_SLT_LO, {8'h00, thr});
    reg_wr(OFS_CTRL, 16'h0007);
    reg_wr(OFS_STAT, 16'h01F0);
    i_partner.start_cond();
    reg_rd(OFS_STAT, rd_v);
    check_bit(rd_v[S_LTO], 1'b1);
    reg_wr(OFS_STAT, 16'h0100);
    reg_wr(OFS_DATA, 16'h0055);
    reg_wr(OFS_CTRL, 16'h000F);
    reg_rd(OFS_STAT, rd_v);
    check_bit(rd_v[S_LTO], 1'b0);
    check_bit(rd_v[S_ARB], 1'b1);
    for (int j = 0; j < 2; j++) begin
      if (j == 1) i_partner.start_cond();
      i_partner.send_byte({own ^ 7'(j == 0), 1'b0}, ack);
      check_bit(ack, j == 0);
    end
    repeat (5) @(posedge clk);
    check_bit(lines_oe.scl, 1'b1);
    reg_rd(OFS_STAT, rd_v);
    check({14'h0000, rd_v[S_MST], rd_v[S_SLV]}, 16'h0001);
    reg_wr(OFS_DATA, 16'h0000);
    repeat (2) @(posedge clk);
    check_bit(lines_oe.scl, 1'b0);
    i_partner.stop_cond();
    repeat (30) @(posedge clk);
    reg_rd(OFS_STAT, rd_v);
    check_bit(rd_v[S_IDLE], 1'b1);
    check({14'h0000, lines_out}, 16'h0000);
    check_bit(i_partner.stuck, 1'b0);
    $display("slave test done");
    wrap_up();
  end
endmodule
